// File: rtl/ftcp_top.sv
// Serial register port and tuning control of the dual filter
`default_nettype none
module ftcp_top
  import ftcp_pkg::*;
#(
  parameter int POR_CYCLES = POWER_UP_CYCLES,
  parameter int FUSE_PULSE = FUSE_PULSE_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sck,
  input wire logic serial_port_select_n,
  input wire logic sdi,
  input wire logic ref_clk,
  output logic sdo,
  output logic sdo_oe_n,
  output logic [3:0] coarse_band,
  output logic [3:0] fine_band,
  output logic port_ready
);
  localparam int NPIN = 4;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1;
  logic [NPIN-1:0] sync2;
  logic [NPIN-1:0] sync3;
  logic [NPIN-1:0] pin_f;
  logic sck_q;
  logic sel_q;
  logic ref_q;
  logic sck_rise;
  logic sel_fall;
  logic sel_rise;
  logic ref_rise;
  logic ref_fall;

  logic [FRAME_BITS-1:0] rx_shift;
  logic [FRAME_BITS-1:0] tx_shift;
  logic [5:0] bit_cnt;
  logic frame_write;
  logic [4:0] wr_addr;
  logic [23:0] wr_data;
  logic sr_armed;
  logic soft_reset;
  logic [15:0] por_cnt;

  logic [23:0] read_ptr;
  logic [23:0] enables;
  logic [23:0] gain_band;
  logic [23:0] fine_override;
  logic [23:0] ref_period;
  logic [23:0] fuse_enable;
  logic [23:0] fuse_index;

  ftcp_cal_type cal_state;
  logic [14:0] cal_timer;
  logic [15:0] cal_count;
  logic [15:0] cal_result;
  logic cal_busy;
  logic [15:0] fuse_bits;
  logic fuse_busy;
  logic fuse_strobe;
  logic cal_start;
  logic [3:0] next_coarse;
  logic [3:0] next_fine;

  assign pin_raw = {ref_clk, sdi, serial_port_select_n, sck};

  // Three-stage synchronisers, a change counts when stages 2 and 3 agree
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge clk) begin
        if (reset) begin
          sync1[g] <= (g == 1);
          sync2[g] <= (g == 1);
          sync3[g] <= (g == 1);
          pin_f[g] <= (g == 1);
        end else begin
          sync1[g] <= pin_raw[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          if (sync2[g] == sync3[g]) begin
            pin_f[g] <= sync3[g];
          end
        end
      end
    end
  endgenerate

  // Edge detection on the filtered pins
  always_ff @(posedge clk) begin
    if (reset) begin
      sck_q <= 1'b0;
      sel_q <= 1'b1;
      ref_q <= 1'b0;
    end else begin
      sck_q <= pin_f[0];
      sel_q <= pin_f[1];
      ref_q <= pin_f[3];
    end
  end

  assign sck_rise = pin_f[0] && !sck_q;
  assign sel_fall = !pin_f[1] && sel_q;
  assign sel_rise = pin_f[1] && !sel_q;
  assign ref_rise = pin_f[3] && !ref_q;
  assign ref_fall = !pin_f[3] && ref_q;

  // Power-up hold-off before the port accepts frames
  always_ff @(posedge clk) begin
    if (reset) begin
      por_cnt <= 16'h0000;
      port_ready <= 1'b0;
    end else if (!port_ready) begin
      por_cnt <= por_cnt + 16'h0001;
      if (por_cnt == 16'(POR_CYCLES - 1)) begin
        port_ready <= 1'b1;
      end
    end
  end

  // Complete, own-address frames only
  assign frame_write = sel_rise && port_ready
    && bit_cnt == 6'(FRAME_BITS)
    && rx_shift[2:0] == CHIP_ID;
  assign wr_addr = rx_shift[7:3];
  assign wr_data = rx_shift[31:8];
  assign cal_start = frame_write && wr_addr == OFS_CAL_STROBE;
  assign fuse_strobe = frame_write && wr_addr == OFS_FUSE_STROBE;
  assign soft_reset = frame_write && wr_addr == OFS_READ_PTR
    && wr_data == SOFT_RESET_FIRE && sr_armed;

  // Register read mux
  function automatic logic [23:0] read_word(input logic [4:0] a);
    logic [23:0] w;
    w = 24'h000000;
    case (a)
      OFS_READ_PTR: w = read_ptr;
      OFS_ENABLES: w = enables;
      OFS_GAIN_BAND: w = gain_band;
      OFS_FINE_BAND: w = fine_override;
      OFS_REF_PERIOD: w = ref_period;
      OFS_STATUS: w = {cal_result, 1'b0, cal_busy, fuse_busy, 5'h00};
      OFS_BAND_READBACK: w = {fuse_bits, coarse_band, fine_band};
      OFS_FUSE_ENABLE: w = fuse_enable;
      OFS_FUSE_INDEX: w = fuse_index;
      default: w = 24'h000000;
    endcase
    return w;
  endfunction

  // Serial shift in and out
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_shift <= '0;
      tx_shift <= '0;
      bit_cnt <= 6'h00;
      sdo <= 1'b0;
    end else if (sel_fall) begin
      bit_cnt <= 6'h00;
      tx_shift <= {read_word(read_ptr[4:0]), read_ptr[4:0], CHIP_ID};
    end else if (sck_rise && !pin_f[1]) begin
      rx_shift <= {rx_shift[30:0], pin_f[2]};
      if (bit_cnt != 6'h3f) begin
        bit_cnt <= bit_cnt + 6'h01;
      end
      sdo <= tx_shift[31];
      tx_shift <= {tx_shift[30:0], 1'b0};
    end
  end

  // Output enable follows the chip address of the last full frame
  always_ff @(posedge clk) begin
    if (reset) begin
      sdo_oe_n <= 1'b1;
    end else if (sel_rise && port_ready && bit_cnt == 6'(FRAME_BITS)) begin
      sdo_oe_n <= rx_shift[2:0] != CHIP_ID;
    end
  end

  // Soft reset arming
  always_ff @(posedge clk) begin
    if (reset) begin
      sr_armed <= 1'b0;
    end else if (frame_write) begin
      sr_armed <= wr_addr == OFS_READ_PTR && wr_data == SOFT_RESET_ARM;
    end
  end

  // Writable registers, stored at the end of each complete own-address frame once the port is ready
  always_ff @(posedge clk) begin
    if (reset || soft_reset) begin
      read_ptr <= REG_RESET;
      enables <= REG_RESET;
      gain_band <= REG_RESET;
      fine_override <= REG_RESET;
      ref_period <= REG_RESET;
      fuse_enable <= REG_RESET;
      fuse_index <= REG_RESET;
    end else if (frame_write) begin
      case (wr_addr)
        OFS_READ_PTR: read_ptr <= wr_data;
        OFS_ENABLES: enables <= wr_data;
        OFS_GAIN_BAND: gain_band <= wr_data;
        OFS_FINE_BAND: fine_override <= wr_data;
        OFS_REF_PERIOD: ref_period <= wr_data;
        OFS_FUSE_ENABLE: fuse_enable <= wr_data;
        OFS_FUSE_INDEX: fuse_index <= wr_data;
        default: ;
      endcase
    end
  end

  // Calibration: count reference edges over the programmed window
  always_ff @(posedge clk) begin
    if (reset || soft_reset) begin
      cal_state <= FTCP_CAL_IDLE;
      cal_timer <= 15'h0000;
      cal_count <= 16'h0000;
      cal_result <= 16'h0000;
      cal_busy <= 1'b0;
    end else begin
      case (cal_state)
        FTCP_CAL_IDLE: begin
          if (cal_start && enables[ENA_CAL_BIT]) begin
            cal_state <= FTCP_CAL_RUN;
            cal_timer <= ref_period[REF_WINDOW_W-1:0];
            cal_count <= 16'h0000;
            cal_busy <= 1'b1;
          end
        end
        FTCP_CAL_RUN: begin
          if (ref_rise || (ref_fall && enables[ENA_DOUBLER_BIT])) begin
            cal_count <= cal_count + 16'h0001;
          end
          if (cal_timer == 15'h0000) begin
            cal_state <= FTCP_CAL_IDLE;
            cal_result <= cal_count;
            cal_busy <= 1'b0;
          end else begin
            cal_timer <= cal_timer - 15'h0001;
          end
        end
        default: cal_state <= FTCP_CAL_IDLE;
      endcase
    end
  end

  // Choice of band codes
  always_comb begin
    next_coarse = INTERNAL_COARSE;
    next_fine = cal_result[15:12];
    if (enables[ENA_HOST_CODES_BIT]) begin
      next_coarse = gain_band[COARSE_LSB +: 4];
      next_fine = fine_override[FINE_LSB +: 4];
    end else if (enables[ENA_FUSE_SELECT_BIT]) begin
      next_coarse = fuse_bits[FUSE_COARSE_LSB +: 4];
      next_fine = fuse_bits[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      coarse_band <= 4'h0;
      fine_band <= 4'h0;
    end else begin
      coarse_band <= next_coarse;
      fine_band <= next_fine;
    end
  end

  // Fuse array and its write pulse
  ftcp_fuse #(
    .FUSES(16),
    .PULSE_CYCLES(FUSE_PULSE)
  ) u_fuse (
    .clk(clk),
    .reset(reset),
    .program_enable(fuse_enable[FUSE_PROG_EN_BIT]),
    .bit_index(fuse_index[3:0]),
    .strobe(fuse_strobe),
    .fuse_bits(fuse_bits),
    .busy(fuse_busy)
  );
endmodule
`default_nettype wire

// File: include/ftcp_pkg.sv
// Constants shared by the filter tuning control port
`default_nettype none
package ftcp_pkg;
  // Frame layout
  localparam int FRAME_BITS = 32;
  localparam int DATA_W = 24;
  localparam int ADDR_W = 5;
  localparam logic [2:0] CHIP_ID = 3'h5;
  // Register indexes
  localparam logic [4:0] OFS_READ_PTR = 5'h00;
  localparam logic [4:0] OFS_ENABLES = 5'h01;
  localparam logic [4:0] OFS_GAIN_BAND = 5'h02;
  localparam logic [4:0] OFS_FINE_BAND = 5'h03;
  localparam logic [4:0] OFS_CAL_STROBE = 5'h04;
  localparam logic [4:0] OFS_REF_PERIOD = 5'h05;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_BAND_READBACK = 5'h0a;
  localparam logic [4:0] OFS_FUSE_ENABLE = 5'h0b;
  localparam logic [4:0] OFS_FUSE_INDEX = 5'h0c;
  localparam logic [4:0] OFS_FUSE_STROBE = 5'h0d;
  // Field positions
  localparam int ENA_CAL_BIT = 0;
  localparam int ENA_DOUBLER_BIT = 1;
  localparam int ENA_HOST_CODES_BIT = 4;
  localparam int ENA_FUSE_SELECT_BIT = 13;
  localparam int COARSE_LSB = 6;
  localparam int FINE_LSB = 0;
  localparam int FUSE_PROG_EN_BIT = 0;
  localparam int STAT_FUSE_BUSY_BIT = 5;
  localparam int STAT_CAL_BUSY_BIT = 6;
  localparam int STAT_RESULT_LSB = 8;
  localparam int REF_WINDOW_W = 15;
  localparam int FUSE_COARSE_LSB = 4;
  // Reset values and soft reset sequence
  localparam logic [23:0] REG_RESET = 24'h000000;
  localparam logic [23:0] SOFT_RESET_ARM = 24'h000020;
  localparam logic [23:0] SOFT_RESET_FIRE = 24'h000000;
  localparam logic [3:0] INTERNAL_COARSE = 4'h0;
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int POWER_UP_US = 250;
  localparam int POWER_UP_CYCLES = POWER_UP_US * (CLK_HZ / 1_000_000);
  localparam int FUSE_PULSE_US = 10;
  localparam int FUSE_PULSE_CYCLES = FUSE_PULSE_US * (CLK_HZ / 1_000_000);
  typedef enum logic [0:0] {FTCP_CAL_IDLE, FTCP_CAL_RUN} ftcp_cal_type;
endpackage
`default_nettype wire

// File: rtl/ftcp_fuse.sv
// One-time fuse array with timed write pulse
`default_nettype none
module ftcp_fuse
  import ftcp_pkg::*;
#(
  parameter int FUSES = 16,
  parameter int PULSE_CYCLES = FUSE_PULSE_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic program_enable,
  input wire logic [3:0] bit_index,
  input wire logic strobe,
  output logic [FUSES-1:0] fuse_bits,
  output logic busy
);
  logic [15:0] pulse_cnt;
  logic [3:0] target;

  // Write pulse timing
  always_ff @(posedge clk) begin
    if (reset) begin
      busy <= 1'b0;
      pulse_cnt <= 16'h0000;
      target <= 4'h0;
    end else if (busy) begin
      if (pulse_cnt == 16'(PULSE_CYCLES - 1)) begin
        busy <= 1'b0;
      end
      pulse_cnt <= pulse_cnt + 16'h0001;
    end else if (strobe && program_enable) begin
      busy <= 1'b1;
      pulse_cnt <= 16'h0000;
      target <= bit_index;
    end
  end

  // Fuses only go from 0 to 1, except that reset clears them all
  always_ff @(posedge clk) begin
    if (reset) begin
      fuse_bits <= '0;
    end else if (busy && pulse_cnt == 16'(PULSE_CYCLES - 1)) begin
      fuse_bits[target] <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: sim/ftcp_top_checker.sv
// Port timing checks for the filter tuning control port
`default_nettype none
module ftcp_top_checker
  import ftcp_pkg::*;
#(
  parameter int POR_CYCLES = 20
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sck,
  input wire logic serial_port_select_n,
  input wire logic sdi,
  input wire logic ref_clk,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  input wire logic [3:0] coarse_band,
  input wire logic [3:0] fine_band,
  input wire logic port_ready
);
  int por_cnt;
  int rise_cnt;
  int since_rise;
  logic [2:0] chip;
  always_ff @(posedge clk) begin
    if (reset) por_cnt <= 0;
    else if (por_cnt < 100000) por_cnt <= por_cnt + 1;
  end
  always_ff @(posedge clk) begin
    if (reset) since_rise <= 20;
    else if ($rose(sck)) since_rise <= 0;
    else if (since_rise < 20) since_rise <= since_rise + 1;
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      rise_cnt <= 0;
      chip <= 3'h0;
    end else if ($fell(serial_port_select_n)) rise_cnt <= 0;
    else if (!serial_port_select_n && $rose(sck)) begin
      rise_cnt <= rise_cnt + 1;
      chip <= {chip[1:0], sdi};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_idle_defaults;
    !port_ready |-> sdo_oe_n && coarse_band == 4'h0 && fine_band == 4'h0;
  endproperty
  a_idle_defaults: assert property (p_idle_defaults)
    else $error("outputs not at defaults before ready");
  property p_por_time;
    $rose(port_ready) |-> por_cnt inside {[POR_CYCLES - 2:POR_CYCLES + 2]};
  endproperty
  a_por_time: assert property (p_por_time)
    else $error("ready at wrong time after reset");
  property p_ready_holds;
    port_ready |=> port_ready;
  endproperty
  a_ready_holds: assert property (p_ready_holds)
    else $error("ready dropped");
  property p_oe_quiet;
    $changed(sdo_oe_n) |-> serial_port_select_n && $past(serial_port_select_n);
  endproperty
  a_oe_quiet: assert property (p_oe_quiet)
    else $error("output enable changed inside a frame");
  property p_oe_full_frame;
    $fell(sdo_oe_n) |-> rise_cnt == 32;
  endproperty
  a_oe_full_frame: assert property (p_oe_full_frame)
    else $error("output enabled without a 32 bit frame");
  property p_oe_follows_chip;
    $rose(serial_port_select_n) && rise_cnt == 32 && port_ready
      |-> ##[1:8] (sdo_oe_n == (chip != CHIP_ID));
  endproperty
  a_oe_follows_chip: assert property (p_oe_follows_chip)
    else $error("output enable does not follow chip address");
  property p_sdo_on_rise;
    $changed(sdo) |-> since_rise inside {[1:7]};
  endproperty
  a_sdo_on_rise: assert property (p_sdo_on_rise)
    else $error("serial output changed away from a clock rise");
  property p_band_quiet;
    $changed(coarse_band) |-> serial_port_select_n;
  endproperty
  a_band_quiet: assert property (p_band_quiet)
    else $error("coarse code changed inside a frame");
  c_ready: cover property ($rose(port_ready));
  c_own: cover property ($fell(sdo_oe_n));
  c_band: cover property ($changed(coarse_band));
endmodule
`default_nettype wire

// File: sim/ftcp_host.sv
// Serial host model that frames transfers on the port
`default_nettype none
module ftcp_host (
  input wire logic clk,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  output logic sck,
  output logic serial_port_select_n,
  output logic sdi,
  output logic [31:0] rd_word,
  output logic rd_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last = 1'b0;
  // Released line toggles, so a stale value never passes
  wire logic sdo_line = sdo_oe_n ? ~last : sdo;
  always @(posedge clk) last <= sdo_line;
  initial begin
    sck = 1'b0;
    serial_port_select_n = 1'b1;
    sdi = 1'b0;
    rd_word = 32'h0;
    rd_done = 1'b0;
  end
  // 400 ns clock, still between frames; bit read just before next rise
  task automatic frame(input logic [31:0] w);
    logic [31:0] r;
    serial_port_select_n <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      sdi <= w[i];
      repeat (4) @(posedge clk);
      if (i < 31) r[i+1] = sdo_line;
      sck <= 1'b1;
      repeat (4) @(posedge clk);
      sck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    r[0] = sdo_line;
    serial_port_select_n <= 1'b1;
    sdi <= ~sdi;
    rd_word <= r;
    rd_done <= 1'b1;
    @(posedge clk);
    rd_done <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// File: sim/ftcp_top_tb.sv
// Self-checking bench for the filter tuning control port
`default_nettype none
module ftcp_top_tb;
  import ftcp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic care; logic [31:0] w;} ftcp_note_type;
  ftcp_note_type notes[$];
  ftcp_note_type note;
  logic clk, reset, ref_clk, sck, sel_n, sdi, sdo, sdo_oe_n;
  logic port_ready, rd_done;
  logic [3:0] coarse_band, fine_band, cb, fb;
  logic [31:0] rd_word;
  logic [4:0] ptr;
  int n_fail, check_count, seed;
  ftcp_top #(.POR_CYCLES(20), .FUSE_PULSE(200)) i_ftcp_top (.clk(clk),
    .reset(reset), .sck(sck), .serial_port_select_n(sel_n), .sdi(sdi),
    .ref_clk(ref_clk), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
    .coarse_band(coarse_band), .fine_band(fine_band),
    .port_ready(port_ready));
  ftcp_host i_ftcp_host (.clk(clk), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
    .sck(sck), .serial_port_select_n(sel_n), .sdi(sdi),
    .rd_word(rd_word), .rd_done(rd_done));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Reference slow enough to pass the pin filter: period of 6 clocks
  always begin
    repeat (3) @(posedge clk);
    ref_clk <= ~ref_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic xfer(input logic [4:0] a, input logic [23:0] d,
    input logic e, input logic [23:0] x, input logic [2:0] c = 3'h5);
    notes.push_back('{e, {x, ptr, CHIP_ID}});
    i_ftcp_host.frame({d, a, c});
    if (a == OFS_READ_PTR && c == CHIP_ID) ptr = d[4:0];
  endtask
  always @(posedge clk) begin
    if (rd_done === 1'b1) begin
      note = notes.pop_front();
      if (note.care) check(rd_word, note.w);
    end
  end
  initial begin
    #2_000_000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    seed = 88;
    reset = 1'b1;
    ref_clk = 1'b0;
    ptr = 5'h00;
    n_fail = 0;
    check_count = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    for (int k = 0; k < 200 && port_ready !== 1'b1; k++) @(posedge clk);
    check(port_ready, 1'b1);
    check(sdo_oe_n, 1'b1);
    cb = 4'($random(seed));
    fb = 4'($random(seed));
    xfer(OFS_GAIN_BAND, {14'h0, cb, 6'h0}, 0, 0);
    xfer(OFS_FINE_BAND, {20'h0, fb}, 0, 0);
    check(coarse_band, INTERNAL_COARSE);
    xfer(OFS_ENABLES, 24'h000010, 0, 0);
    check(coarse_band, cb);
    check(fine_band, fb);
    xfer(OFS_GAIN_BAND, {14'h0, ~cb, 6'h0}, 0, 0, 3'h2);
    check(coarse_band, cb);
    check(sdo_oe_n, 1'b1);
    xfer(OFS_READ_PTR, 24'h2, 0, 0);
    fb = 4'($random(seed));
    xfer(OFS_FINE_BAND, {20'h0, fb}, 1, {14'h0, cb, 6'h0});
    check(fine_band, fb);
    xfer(OFS_READ_PTR, 24'h8, 1, {14'h0, cb, 6'h0});
    xfer(OFS_CAL_STROBE, 0, 1, 0);
    xfer(OFS_REF_PERIOD, 24'd40, 1, 0);
    xfer(OFS_ENABLES, 24'h000001, 1, 0);
    xfer(OFS_CAL_STROBE, 0, 1, 0);
    xfer(OFS_FUSE_STROBE, 0, 0, 0);
    check(rd_word[14], 1'b1);
    xfer(OFS_FUSE_ENABLE, 24'h1, 0, 0);
    check(rd_word[31:16] inside {[16'd6:16'd7]}, 1'b1);
    check(rd_word[14], 1'b0);
    check(rd_word[13], 1'b0);
    xfer(OFS_ENABLES, 24'h000003, 0, 0);
    xfer(OFS_CAL_STROBE, 0, 0, 0);
    xfer(OFS_FUSE_INDEX, 24'h5, 0, 0);
    check(rd_word[14], 1'b1);
    xfer(OFS_FUSE_STROBE, 0, 0, 0);
    check(rd_word[31:16] inside {[16'd13:16'd14]}, 1'b1);
    xfer(OFS_READ_PTR, 24'ha, 0, 0);
    check(rd_word[13], 1'b1);
    xfer(OFS_ENABLES, 24'h002000, 0, 0);
    check(rd_word[31:16], 16'h0020);
    check(coarse_band, 4'h2);
    xfer(OFS_FUSE_ENABLE, 0, 0, 0);
    xfer(OFS_READ_PTR, SOFT_RESET_ARM, 0, 0);
    xfer(OFS_READ_PTR, SOFT_RESET_FIRE, 0, 0);
    check(coarse_band, 4'h0);
    check(fine_band, 4'h0);
    xfer(OFS_READ_PTR, 24'h1f, 1, 0);
    xfer(OFS_READ_PTR, 24'ha, 1, 0);
    xfer(OFS_READ_PTR, 24'ha, 0, 0);
    check(rd_word[31:16], 16'h0020);
    repeat (4) @(posedge clk);
    report_and_stop();
  end
endmodule
bind ftcp_top ftcp_top_checker #(.POR_CYCLES(POR_CYCLES)) i_ftcp_top_checker (
  .clk(clk), .reset(reset), .sck(sck),
  .serial_port_select_n(serial_port_select_n), .sdi(sdi),
  .ref_clk(ref_clk), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
  .coarse_band(coarse_band), .fine_band(fine_band),
  .port_ready(port_ready));
`default_nettype wire
